// >>> hdl/swt_pkg.sv
/*
  Shared definitions for the self wake-up timer: register indices, field
  positions, reset values, timing constants and the AXI4-Lite carriers.
  Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package swt_pkg;

  // Timing
  localparam int unsigned SYS_CLK_HZ = 100_000_000;
  localparam int unsigned LIRC_HZ = 10_000;
  localparam int unsigned LIRC_CYCLES_DFLT = SYS_CLK_HZ / LIRC_HZ;
  localparam int unsigned LIRC_CNT_W = 14;

  //////////////////////////////////////////////////////////////////////////
  // Register map: index, byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_RELOAD = 10'h086;
  localparam logic [9:0] IDX_CTRL = 10'h08F;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h090;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h091;

  // Control field positions and reset values
  localparam int unsigned CTRL_PRESC_LSB = 0;
  localparam int unsigned CTRL_RUN_BIT = 3;
  localparam int unsigned CTRL_FLAG_BIT = 4;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic flag;
    logic run;
    logic [2:0] presc;
  } swt_ctrl_s;

  localparam swt_ctrl_s CTRL_RST = 5'h00;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } swt_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swt_axi_rsp_s;

  // Terminal prescaler count for a divide setting: 1,4,16,64,256,512,1024,2048
  function automatic logic [10:0] presc_last(input logic [2:0] sel);
    case (sel)
      3'h0: presc_last = 11'h000;
      3'h1: presc_last = 11'h003;
      3'h2: presc_last = 11'h00F;
      3'h3: presc_last = 11'h03F;
      3'h4: presc_last = 11'h0FF;
      3'h5: presc_last = 11'h1FF;
      3'h6: presc_last = 11'h3FF;
      default: presc_last = 11'h7FF;
    endcase
  endfunction

  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == IDX_RELOAD) || (idx == IDX_CTRL) ||
                 (idx == IDX_IRQ_STAT) || (idx == IDX_IRQ_MASK);
  endfunction

endpackage

// >>> hdl/swt_wake_timer.sv
/*
  Self wake-up timer: 8-bit auto-reload up-counter clocked by a 10 kHz tick,
  with prescaler, overflow flag, interrupt status/mask and AXI4-Lite slave.
  Assumes one 100 MHz clock, synchronous active-low reset, and that power
  mode and oscillator-enable inputs are synchronous to that clock.
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module swt_wake_timer #(
  parameter int unsigned LIRC_CYCLES = swt_pkg::LIRC_CYCLES_DFLT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic lirc_on,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  input wire swt_pkg::swt_axi_req_s axi_req,
  output swt_pkg::swt_axi_rsp_s axi_rsp,
  output logic wake_irq,
  output logic lirc_hold
);

  // Divider must give at least three system cycles per slow tick
  if (LIRC_CYCLES < 3 || LIRC_CYCLES >= (1 << swt_pkg::LIRC_CNT_W)) begin : g_bad_cycles
    $error("LIRC_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [swt_pkg::LIRC_CNT_W-1:0] lirc_cnt_reg;
  logic lirc_tick_reg;
  swt_pkg::swt_ctrl_s ctrl_reg;
  logic [7:0] reload_reg;
  logic [7:0] cnt_reg;
  logic [10:0] pre_reg;
  logic run_d_reg;
  logic stat_reg;
  logic mask_reg;
  logic wake_irq_reg;
  logic lirc_hold_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [9:0] wr_idx_reg;
  logic [7:0] wr_data_reg;
  logic wr_strb_reg;
  logic start;
  logic pre_pulse;
  logic overflow;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_reload;
  logic wr_mask;
  logic rd_fire;
  logic [9:0] rd_idx;
  logic [31:0] rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Slow tick divider; stops while the oscillator is off
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lirc_cnt_reg <= '0;
      lirc_tick_reg <= 1'b0;
    end else if (!lirc_on) begin
      lirc_cnt_reg <= '0;
      lirc_tick_reg <= 1'b0;
    end else if (lirc_cnt_reg == swt_pkg::LIRC_CNT_W'(LIRC_CYCLES - 1)) begin
      lirc_cnt_reg <= '0;
      lirc_tick_reg <= 1'b1;
    end else begin
      lirc_cnt_reg <= lirc_cnt_reg + 1'b1;
      lirc_tick_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer core events; sleep inputs deliberately play no part here
  assign start = ctrl_reg.run && !run_d_reg;
  assign pre_pulse = ctrl_reg.run && !start && lirc_tick_reg &&
                     (pre_reg == swt_pkg::presc_last(ctrl_reg.presc));
  assign overflow = pre_pulse && (cnt_reg == swt_pkg::COUNT_TOP);

  // Run edge tracking
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_d_reg <= 1'b0;
    end else begin
      run_d_reg <= ctrl_reg.run;
    end
  end

  // Prescaler; restart on start so the first period is full length
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else if (start || !ctrl_reg.run) begin
      pre_reg <= '0;
    end else if (lirc_tick_reg) begin
      if (pre_reg >= swt_pkg::presc_last(ctrl_reg.presc)) begin
        pre_reg <= '0;
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end

  // Counter: up-count with auto-reload from FF
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (start) begin
      cnt_reg <= reload_reg;
    end else if (pre_pulse) begin
      if (overflow) begin
        cnt_reg <= reload_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ctrl = wr_fire && wr_strb_reg && (wr_idx_reg == swt_pkg::IDX_CTRL);
  assign wr_reload = wr_fire && wr_strb_reg && (wr_idx_reg == swt_pkg::IDX_RELOAD);
  assign wr_mask = wr_fire && wr_strb_reg && (wr_idx_reg == swt_pkg::IDX_IRQ_MASK);

  // Control: overflow set is applied last so it beats a clearing write
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_reg <= swt_pkg::CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg.presc <= wr_data_reg[swt_pkg::CTRL_PRESC_LSB +: 3];
        ctrl_reg.run <= wr_data_reg[swt_pkg::CTRL_RUN_BIT];
        ctrl_reg.flag <= wr_data_reg[swt_pkg::CTRL_FLAG_BIT];
      end
      if (overflow) begin
        ctrl_reg.flag <= 1'b1;
      end
    end
  end

  // Reload value; a write while running is not blocked, result undefined
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reload_reg <= swt_pkg::RELOAD_RST;
    end else if (wr_reload) begin
      reload_reg <= wr_data_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status (clear on read, set wins) and mask
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (rd_fire && rd_idx == swt_pkg::IDX_IRQ_STAT) begin
        stat_reg <= 1'b0;
      end
      if (overflow) begin
        stat_reg <= 1'b1;
      end
      if (wr_mask) begin
        mask_reg <= wr_data_reg[0];
      end
    end
  end

  // Interrupt line and oscillator hold request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wake_irq_reg <= 1'b0;
      lirc_hold_reg <= 1'b0;
    end else begin
      wake_irq_reg <= stat_reg && mask_reg;
      lirc_hold_reg <= ctrl_reg.run && (idle_mode || power_down_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels: address and data taken in either order
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= swt_pkg::RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= 1'b0;
    end else begin
      if (axi_req.awvalid && awready_reg) begin
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
        wr_idx_reg <= axi_req.awaddr[swt_pkg::ADDR_W-1:2];
      end
      if (axi_req.wvalid && wready_reg) begin
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
        wr_data_reg <= axi_req.wdata[7:0];
        wr_strb_reg <= axi_req.wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= swt_pkg::idx_mapped(wr_idx_reg) ? swt_pkg::RESP_OKAY
                                                     : swt_pkg::RESP_SLVERR;
      end
      // Ready returns only after the response, one write at a time
      if (bvalid_reg && axi_req.bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux; reserved bits read zero
  assign rd_fire = axi_req.arvalid && arready_reg;
  assign rd_idx = axi_req.araddr[swt_pkg::ADDR_W-1:2];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      swt_pkg::IDX_RELOAD: rd_word[7:0] = reload_reg;
      swt_pkg::IDX_CTRL: rd_word[4:0] = ctrl_reg;
      swt_pkg::IDX_IRQ_STAT: rd_word[0] = stat_reg;
      swt_pkg::IDX_IRQ_MASK: rd_word[0] = mask_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: data registered one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= swt_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= swt_pkg::idx_mapped(rd_idx) ? swt_pkg::RESP_OKAY
                                               : swt_pkg::RESP_SLVERR;
    end else if (rvalid_reg && axi_req.rready) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign axi_rsp.awready = awready_reg;
  assign axi_rsp.wready = wready_reg;
  assign axi_rsp.bvalid = bvalid_reg;
  assign axi_rsp.bresp = bresp_reg;
  assign axi_rsp.arready = arready_reg;
  assign axi_rsp.rvalid = rvalid_reg;
  assign axi_rsp.rdata = rdata_reg;
  assign axi_rsp.rresp = rresp_reg;
  assign wake_irq = wake_irq_reg;
  assign lirc_hold = lirc_hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_count_step;
    @(posedge clock) disable iff (!rst_n)
    pre_pulse && !overflow |=> cnt_reg == 8'($past(cnt_reg) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count step wrong");

  property p_reload;
    @(posedge clock) disable iff (!rst_n)
    overflow |=> (cnt_reg == $past(reload_reg)) && ctrl_reg.flag;
  endproperty
  a_reload: assert property (p_reload) else $error("overflow reload wrong");

  property p_flag_hold;
    @(posedge clock) disable iff (!rst_n)
    ctrl_reg.flag && !(wr_ctrl && !wr_data_reg[swt_pkg::CTRL_FLAG_BIT]) |=> ctrl_reg.flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  property p_halt;
    @(posedge clock) disable iff (!rst_n)
    !ctrl_reg.run |=> $stable(cnt_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_div_one;
    @(posedge clock) disable iff (!rst_n)
    ctrl_reg.run && !start && lirc_tick_reg && ctrl_reg.presc == 3'h0 |-> pre_pulse;
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one missed");

  property p_div_four;
    @(posedge clock) disable iff (!rst_n)
    ctrl_reg.run && !start && lirc_tick_reg && ctrl_reg.presc == 3'h1 && pre_reg < 11'h003
      |-> !pre_pulse ##1 pre_reg == 11'($past(pre_reg) + 11'h001);
  endproperty
  a_div_four: assert property (p_div_four) else $error("divide by four wrong");

  property p_irq;
    @(posedge clock) disable iff (!rst_n)
    overflow ##1 mask_reg |=> wake_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_reset_zero;
    @(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> ctrl_reg == swt_pkg::CTRL_RST && !wake_irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("control not zero");

  property p_start;
    @(posedge clock) disable iff (!rst_n)
    start |=> cnt_reg == $past(reload_reg) && pre_reg == 11'h000;
  endproperty
  a_start: assert property (p_start) else $error("start load wrong");

  property p_sleep_count;
    @(posedge clock) disable iff (!rst_n)
    pre_pulse && !overflow && power_down_mode |=> cnt_reg != $past(cnt_reg);
  endproperty
  a_sleep_count: assert property (p_sleep_count) else $error("halted in sleep");

  property p_hold;
    @(posedge clock) disable iff (!rst_n)
    ctrl_reg.run && (idle_mode || power_down_mode) |=> lirc_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("oscillator hold missing");

endmodule // swt_wake_timer

// >>> tb/swt_tb.sv
/*
  Self-checking bench for the wake timer: register reset values, refusals,
  counting period for every divide setting, sticky flag, mask and hold.
  Assumes the block alone under test, driven over its AXI4-Lite port.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
  localparam int LC = 4; // Short slow tick, one every four clocks, above the three-clock minimum
  localparam logic [9:0] A_RL = swt_pkg::IDX_RELOAD;
  localparam logic [9:0] A_CT = swt_pkg::IDX_CTRL;
  localparam logic [9:0] A_ST = swt_pkg::IDX_IRQ_STAT;
  localparam logic [9:0] A_MK = swt_pkg::IDX_IRQ_MASK;
  localparam logic [1:0] OK = swt_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = swt_pkg::RESP_SLVERR;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic lirc_on = 1'h0;
  logic idle_mode = 1'h0;
  logic power_down_mode = 1'h0;
  swt_pkg::swt_axi_req_s req = '0;
  swt_pkg::swt_axi_rsp_s rsp;
  logic wake_irq;
  logic lirc_hold;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int t_b, t0, t1, t2, per;
  logic [7:0] rl;

  swt_wake_timer #(.LIRC_CYCLES(LC)) dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .lirc_on(lirc_on),
    .idle_mode(idle_mode),
    .power_down_mode(power_down_mode),
    .axi_req(req),
    .axi_rsp(rsp),
    .wake_irq(wake_irq),
    .lirc_hold(lirc_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a cycle stamp, updated late so readers see one value per edge
  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  task automatic summarize;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Write one register; address and data offered together, each held until taken
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] st,
                        input logic [1:0] er);
    bit got;
    int n;
    got = 0;
    n = 0;
    @(posedge clock);
    req.awvalid <= 1'h1;
    req.awaddr <= {idx, 2'h0};
    req.wvalid <= 1'h1;
    req.wdata <= {24'h0, d};
    req.wstrb <= st;
    req.bready <= 1'h1;
    while (!got) begin
      @(posedge clock);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      if (rsp.bvalid) begin
        got = 1;
        t_b = cyc;
        req.bready <= 1'h0;
        `CHK("bresp", er, rsp.bresp)
      end
      if (n > 50) begin
        failures++;
        summarize();
      end
    end
  endtask

  // Read one register and compare data and response
  task automatic axi_rd(input string nm, input logic [9:0] idx, input logic [7:0] e,
                        input logic [1:0] er);
    bit got;
    int n;
    got = 0;
    n = 0;
    @(posedge clock);
    req.araddr <= {idx, 2'h0};
    req.arvalid <= 1'h1;
    req.rready <= 1'h1;
    while (!got) begin
      @(posedge clock);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      if (rsp.rvalid) begin
        got = 1;
        req.rready <= 1'h0;
        `CHK(nm, {24'h0, e}, rsp.rdata)
        `CHK("rresp", er, rsp.rresp)
      end
      if (n > 50) begin
        failures++;
        summarize();
      end
    end
  endtask

  // Bounded wait for the interrupt level, returns the stamp of first sight
  task automatic wait_irq(output int t, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
      if (n > lim) begin
        failures++;
        summarize();
      end
    end while (wake_irq !== 1'h1);
    t = cyc;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    `CHK("irq after reset", 1'h0, wake_irq)
    axi_rd("reload", A_RL, 8'h00, OK);
    axi_rd("ctrl", A_CT, 8'h00, OK);
    axi_rd("stat", A_ST, 8'h00, OK);
    axi_rd("mask", A_MK, 8'h00, OK);
    // Unmapped place and a write with the data lane disabled
    axi_wr(10'h0AA, 8'h5A, 4'hF, ERR);
    axi_rd("unmapped", 10'h0AA, 8'h00, ERR);
    axi_wr(A_RL, 8'h55, 4'hE, OK);
    axi_rd("reload", A_RL, 8'h00, OK);
    axi_wr(A_CT, 8'hE5, 4'hF, OK);
    axi_rd("ctrl", A_CT, 8'h05, OK);
    axi_wr(A_MK, 8'h01, 4'hF, OK);
    axi_rd("mask", A_MK, 8'h01, OK);
    // Oscillator enable input is raised by the bench and given time to settle
    lirc_on <= 1'h1;
    repeat (20) @(posedge clock);
    // Every divide setting, some under sleep inputs, where counting must go on
    for (int i = 0; i < 8; i++) begin
      rl = (i == 0) ? 8'hFC : 8'hFF;
      per = LC * (256 - int'(rl)) * (1 << ((i < 5) ? 2 * i : i + 4));
      power_down_mode <= (i == 2);
      idle_mode <= (i == 5);
      axi_wr(A_RL, rl, 4'hF, OK);
      axi_wr(A_CT, 8'h08 | 8'(i), 4'hF, OK);
      t0 = t_b;
      wait_irq(t1, 2 * per + 100);
      `CHK("first period", 1'h1, 1'((t1 - t0 >= per - LC) && (t1 - t0 <= per + LC + 2)))
      `CHK("osc hold", 1'((i == 2) || (i == 5)), lirc_hold)
      axi_rd("stat", A_ST, 8'h01, OK);
      wait_irq(t2, 2 * per + 100);
      `CHK("period", per, t2 - t1)
      axi_rd("ctrl run", A_CT, 8'h18 | 8'(i), OK);
      axi_wr(A_CT, 8'(i), 4'hF, OK);
      axi_rd("stat", A_ST, 8'h01, OK);
      repeat (60) @(posedge clock);
      `CHK("halted irq", 1'h0, wake_irq)
      `CHK("hold off", 1'h0, lirc_hold)
      axi_rd("ctrl halted", A_CT, 8'(i), OK);
    end
    // Masked overflow, then unmask, clear and sticky flag while halted
    power_down_mode <= 1'h0;
    idle_mode <= 1'h0;
    axi_wr(A_MK, 8'h00, 4'hF, OK);
    axi_wr(A_RL, 8'hFC, 4'hF, OK);
    axi_wr(A_CT, 8'h08, 4'hF, OK);
    repeat (40) @(posedge clock);
    `CHK("masked irq", 1'h0, wake_irq)
    axi_rd("ctrl flag", A_CT, 8'h18, OK);
    axi_wr(A_MK, 8'h01, 4'hF, OK);
    repeat (2) @(posedge clock);
    `CHK("unmasked irq", 1'h1, wake_irq)
    axi_wr(A_CT, 8'h10, 4'hF, OK);
    axi_rd("stat", A_ST, 8'h01, OK);
    repeat (2) @(posedge clock);
    `CHK("cleared irq", 1'h0, wake_irq)
    repeat (60) @(posedge clock);
    axi_rd("ctrl sticky", A_CT, 8'h10, OK);
    axi_wr(A_CT, 8'h00, 4'hF, OK);
    axi_rd("ctrl clear", A_CT, 8'h00, OK);
    // Reset in mid-run with the interrupt raised: all back to zero
    axi_wr(A_CT, 8'h08, 4'hF, OK);
    repeat (40) @(posedge clock);
    `CHK("irq before reset", 1'h1, wake_irq)
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    `CHK("irq after mid reset", 1'h0, wake_irq)
    axi_rd("ctrl mid reset", A_CT, 8'h00, OK);
    axi_rd("reload mid reset", A_RL, 8'h00, OK);
    axi_rd("mask mid reset", A_MK, 8'h00, OK);
    axi_rd("stat mid reset", A_ST, 8'h00, OK);
    summarize();
  end
endmodule // tb
